// ==== hw/csc_i2c_defines.svh ====
// named constants of the colour space converter serial control receiver
// assumes inclusion by bare name from the loader module and the testbench
`ifndef CSC_I2C_DEFINES_SVH
`define CSC_I2C_DEFINES_SVH

// -----------------------------------------------------------------------
// sub-addresses
// -----------------------------------------------------------------------
`define CSC_SUB_CONTROL  8'h00
`define CSC_SUB_RED      8'h01
`define CSC_SUB_GREEN    8'h02
`define CSC_SUB_BLUE     8'h03
`define CSC_SUB_ALL      8'h04

// -----------------------------------------------------------------------
// control byte: reset value and format codes
// -----------------------------------------------------------------------
`define CSC_CTRL_RESET   8'h24
`define CSC_FMT_411_MAX  3'h1
`define CSC_FMT_422_MAX  3'h3
`define CSC_FMT_BYPASS   3'h4

// -----------------------------------------------------------------------
// serial receiver counts
// -----------------------------------------------------------------------
`define CSC_LAST_BIT     3'h7
`define CSC_BIT_STEP     3'h1
`define CSC_ADDR_STEP    8'h01
`define CSC_RW_WRITE     1'b0

`endif

// ==== hw/csc_pkg.sv ====
// types shared by the converter control receiver and its testbench
// assumes the defines header is on the include path
package csc_pkg;

    // events handed from the serial clock domain to the pixel clock domain
    typedef enum logic [1:0] {EV_SUB, EV_DATA, EV_STOP} csc_evt_kind_e;

    typedef struct packed {
        csc_evt_kind_e kind;
        logic [7:0]    data;
    } csc_evt_s;

    // control byte layout, D7 down to D0
    typedef struct packed {
        logic [1:0] spare;
        logic       out_en;
        logic       in_pass;
        logic       matrix;
        logic [2:0] fmt;
    } csc_ctrl_s;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } csc_pixel_s;

    typedef enum logic [1:0] {FLT_411, FLT_422, FLT_BYPASS} csc_filter_e;

    typedef enum logic [2:0] {TS_NONE, TS_CTRL, TS_RED, TS_GREEN, TS_BLUE,
                              TS_ALL} csc_tsel_e;

    typedef enum logic [1:0] {LK_IDLE, LK_BITS, LK_ACK_WAIT, LK_ACK_HOLD} csc_lk_state_e;

    typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_DATA} csc_phase_e;

endpackage : csc_pkg

// ==== hw/csc_lut_ram.sv ====
// one video lookup table: simple dual port, registered read data
// assumes write and read share one clock; contents are not reset
`timescale 1ns/100ps
module csc_lut_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          clock,
    input  wire logic          resetn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_ff;

    // -------------------------------------------------------------------
    // storage: only written locations change, no reset on the array
    // -------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data leaves through a register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_data_ff <= '0;
        end
        else
        begin
            rd_data_ff <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;

endmodule : csc_lut_ram

// ==== hw/csc_i2c_control_lut_loader.sv ====
// serial control receiver and lookup table loader of the colour converter
// assumes a bus master on scl/sda sampled by i2c_clk, pixels on clock
`timescale 1ns/100ps
`include "csc_i2c_defines.svh"

// Functional notes
// - table sub-address puts tables in write mode
// - stop condition returns tables to read mode
// - first data byte loads table address counter
// - counter steps by one per written byte
// - each table write has a data strobe
// - three 256 by 8 tables, per channel
// - sub-addresses 01/02/03 pick red/green/blue
// - sub-address 04 writes all three tables
// - partial loads leave other entries untouched
// - bypass input skips tables per clock
// - reset gives format 4, no matrix, outputs on
// - sub-address 00 byte updates the control register
// - bits 2..0 choose the input filter
// - bits 3,4,5 matrix, input pass, output drive
// - equal latency whether matrix used or not
module csc_i2c_control_lut_loader #(
    parameter logic [6:0] DEV_ADDR = 7'h3A  // bus address, value arbitrary
) (
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                i2c_clk,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe,
    input  wire csc_pkg::csc_pixel_s pix_in,
    input  wire logic                table_bypass,
    output csc_pkg::csc_pixel_s      pix_out,
    output logic [2:0]               input_format_sel,
    output csc_pkg::csc_filter_e     filter_mode,
    output logic                     matrix_enable,
    output logic                     input_pass_enable,
    output logic                     output_drive_enable,
    output logic                     table_rw_direction
);
    import csc_pkg::*;

    function automatic csc_tsel_e tsel_decode(input logic [7:0] sub);
        unique case (sub)
            `CSC_SUB_CONTROL: return TS_CTRL;
            `CSC_SUB_RED:     return TS_RED;
            `CSC_SUB_GREEN:   return TS_GREEN;
            `CSC_SUB_BLUE:    return TS_BLUE;
            `CSC_SUB_ALL:     return TS_ALL;
            default:          return TS_NONE;
        endcase
    endfunction : tsel_decode

    function automatic logic [2:0] we_mask(input csc_tsel_e sel);
        return {sel == TS_RED || sel == TS_ALL, sel == TS_GREEN || sel == TS_ALL,
                sel == TS_BLUE || sel == TS_ALL};
    endfunction : we_mask

    function automatic csc_filter_e filter_decode(input logic [2:0] fmt);
        if (fmt <= `CSC_FMT_411_MAX)
            return FLT_411;
        else if (fmt <= `CSC_FMT_422_MAX)
            return FLT_422;
        else
            return FLT_BYPASS;
    endfunction : filter_decode

    // -------------------------------------------------------------------
    // link domain: reset release and pin synchronisers
    // -------------------------------------------------------------------
    logic [1:0]    lk_rst_ff;
    logic [1:0]    scl_sync_ff;
    logic [1:0]    sda_sync_ff;
    logic          scl_prev_ff;
    logic          sda_prev_ff;
    logic          lk_rstn;

    // reset asserts at once but releases on the link clock
    always_ff @(posedge i2c_clk or negedge resetn)
    begin
        if (!resetn)
            lk_rst_ff <= '0;
        else
            lk_rst_ff <= {lk_rst_ff[0], 1'b1};
    end
    assign lk_rstn = lk_rst_ff[1];

    // two stages per pin, a third copy for edge detection
    always_ff @(posedge i2c_clk or negedge lk_rstn)
    begin
        if (!lk_rstn)
        begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            scl_prev_ff <= scl_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    // -------------------------------------------------------------------
    // link domain: serial receiver
    // -------------------------------------------------------------------
    csc_lk_state_e lk_state_ff, nxt_lk_state;
    csc_phase_e    phase_ff, nxt_phase;
    logic [2:0]    bit_cnt_ff, nxt_bit_cnt;
    logic [7:0]    shift_ff, nxt_shift;
    logic          sda_oe_ff, nxt_sda_oe;
    csc_evt_s      evt_ff, nxt_evt;
    logic          req_ff, nxt_req;
    logic          scl_s, sda_s;

    assign scl_s = scl_sync_ff[1];
    assign sda_s = sda_sync_ff[1];

    // start and stop win over bit handling; a sub-address or data byte is posted at its 8th bit
    always_comb
    begin
        logic [7:0] byte_v;
        byte_v       = {shift_ff[6:0], sda_s};
        nxt_lk_state = lk_state_ff;
        nxt_phase    = phase_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_shift    = shift_ff;
        nxt_sda_oe   = sda_oe_ff;
        nxt_evt      = evt_ff;
        nxt_req      = req_ff;
        if (scl_s && scl_prev_ff && sda_prev_ff && !sda_s)
        begin
            nxt_lk_state = LK_BITS;
            nxt_phase    = PH_ADDR;
            nxt_bit_cnt  = '0;
            nxt_sda_oe   = 1'b0;
        end
        else if (scl_s && scl_prev_ff && !sda_prev_ff && sda_s)
        begin
            if (phase_ff != PH_ADDR)
            begin
                nxt_evt = '{kind: EV_STOP, data: shift_ff};
                nxt_req = !req_ff;
            end
            nxt_lk_state = LK_IDLE;
            nxt_phase    = PH_ADDR;
            nxt_sda_oe   = 1'b0;
        end
        else
        begin
            unique case (lk_state_ff)
                LK_IDLE: ;
                LK_BITS:
                    if (scl_s && !scl_prev_ff)
                    begin
                        nxt_shift   = byte_v;
                        nxt_bit_cnt = bit_cnt_ff + `CSC_BIT_STEP;
                        if (bit_cnt_ff == `CSC_LAST_BIT)
                        begin
                            if (phase_ff == PH_ADDR)
                            begin
                                if (byte_v[7:1] == DEV_ADDR && byte_v[0] == `CSC_RW_WRITE)
                                begin
                                    nxt_lk_state = LK_ACK_WAIT;
                                    nxt_phase    = PH_SUB;
                                end
                                else
                                    nxt_lk_state = LK_IDLE;
                            end
                            else
                            begin
                                nxt_evt.kind = (phase_ff == PH_SUB) ? EV_SUB : EV_DATA;
                                nxt_evt.data = byte_v;
                                nxt_req      = !req_ff;
                                nxt_phase    = PH_DATA;
                                nxt_lk_state = LK_ACK_WAIT;
                            end
                        end
                    end
                LK_ACK_WAIT:
                    if (!scl_s && scl_prev_ff)
                    begin
                        nxt_sda_oe   = 1'b1;
                        nxt_lk_state = LK_ACK_HOLD;
                    end
                LK_ACK_HOLD:
                    if (!scl_s && scl_prev_ff)
                    begin
                        nxt_sda_oe   = 1'b0;
                        nxt_bit_cnt  = '0;
                        nxt_lk_state = LK_BITS;
                    end
            endcase
        end
    end

    always_ff @(posedge i2c_clk or negedge lk_rstn)
    begin
        if (!lk_rstn)
        begin
            lk_state_ff <= LK_IDLE;
            phase_ff    <= PH_ADDR;
            bit_cnt_ff  <= '0;
            shift_ff    <= '0;
            sda_oe_ff   <= 1'b0;
            evt_ff      <= '{kind: EV_STOP, data: 8'h00};
            req_ff      <= 1'b0;
        end
        else
        begin
            lk_state_ff <= nxt_lk_state;
            phase_ff    <= nxt_phase;
            bit_cnt_ff  <= nxt_bit_cnt;
            shift_ff    <= nxt_shift;
            sda_oe_ff   <= nxt_sda_oe;
            evt_ff      <= nxt_evt;
            req_ff      <= nxt_req;
        end
    end

    // open drain: the data line is only ever pulled low
    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_ff;

    // -------------------------------------------------------------------
    // pixel domain: event crossing and table loader
    // -------------------------------------------------------------------
    logic [2:0]    req_sync_ff;
    csc_tsel_e     tsel_ff, nxt_tsel;
    logic          dir_ff, nxt_dir;
    logic          first_ff, nxt_first;
    logic [7:0]    addr_ff, nxt_addr;
    csc_ctrl_s     ctrl_ff, nxt_ctrl;
    csc_filter_e   filter_ff, nxt_filter;
    logic [2:0]    we_ff, nxt_we;
    logic [7:0]    waddr_ff, nxt_waddr;
    logic [7:0]    wdata_ff, nxt_wdata;
    logic          evt_seen;

    // the event word is held in the link domain until the next byte or a stop,
    // at least two serial clocks later, so it is steady when the toggle lands
    assign evt_seen = req_sync_ff[1] ^ req_sync_ff[2];

    always_comb
    begin
        nxt_tsel  = tsel_ff;
        nxt_dir   = dir_ff;
        nxt_first = first_ff;
        nxt_addr  = addr_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_we    = '0;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        if (evt_seen)
        begin
            unique case (evt_ff.kind)
                EV_SUB:
                begin
                    nxt_tsel  = tsel_decode(evt_ff.data);
                    nxt_dir   = |we_mask(tsel_decode(evt_ff.data));
                    nxt_first = 1'b1;
                end
                EV_DATA:
                    if (tsel_ff == TS_CTRL)
                        nxt_ctrl = evt_ff.data;
                    else if (tsel_ff != TS_NONE)
                    begin
                        if (first_ff)
                        begin
                            nxt_addr  = evt_ff.data;
                            nxt_first = 1'b0;
                        end
                        else
                        begin
                            nxt_we    = we_mask(tsel_ff);
                            nxt_waddr = addr_ff;
                            nxt_wdata = evt_ff.data;
                            nxt_addr  = addr_ff + `CSC_ADDR_STEP;
                        end
                    end
                EV_STOP:
                begin
                    nxt_dir  = 1'b0;
                    nxt_tsel = TS_NONE;
                end
                default: ;
            endcase
        end
        nxt_filter = filter_decode(nxt_ctrl.fmt);
    end

    // control state is only trustworthy after this reset
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            req_sync_ff <= '0;
            tsel_ff     <= TS_NONE;
            dir_ff      <= 1'b0;
            first_ff    <= 1'b0;
            addr_ff     <= '0;
            ctrl_ff     <= `CSC_CTRL_RESET;
            filter_ff   <= FLT_BYPASS;
            we_ff       <= '0;
            waddr_ff    <= '0;
            wdata_ff    <= '0;
        end
        else
        begin
            req_sync_ff <= {req_sync_ff[1:0], req_ff};
            tsel_ff     <= nxt_tsel;
            dir_ff      <= nxt_dir;
            first_ff    <= nxt_first;
            addr_ff     <= nxt_addr;
            ctrl_ff     <= nxt_ctrl;
            filter_ff   <= nxt_filter;
            we_ff       <= nxt_we;
            waddr_ff    <= nxt_waddr;
            wdata_ff    <= nxt_wdata;
        end
    end

    assign input_format_sel    = ctrl_ff.fmt;
    assign filter_mode         = filter_ff;
    assign matrix_enable       = ctrl_ff.matrix;
    assign input_pass_enable   = ctrl_ff.in_pass;
    assign output_drive_enable = ctrl_ff.out_en;
    assign table_rw_direction  = dir_ff;

    // -------------------------------------------------------------------
    // pixel domain: tables and bypass
    // -------------------------------------------------------------------
    logic [2:0][7:0] pix_in_v;
    logic [2:0][7:0] rd_data;
    csc_pixel_s      pix_d1_ff, nxt_pix_d1;
    csc_pixel_s      pix_out_ff, nxt_pix_out;

    assign pix_in_v = pix_in;

    // one table per channel: index 2 red, 1 green, 0 blue
    for (genvar ch = 0; ch < 3; ch++)
    begin : g_table
        csc_lut_ram #(
            .AW (8),
            .DW (8)
        ) u_ram (
            .clock   (clock),
            .resetn  (resetn),
            .wr_en   (we_ff[ch]),
            .wr_addr (waddr_ff),
            .wr_data (wdata_ff),
            .rd_addr (pix_in_v[ch]),
            .rd_data (rd_data[ch])
        );
    end

    // both paths take two clocks, whatever the bypass or matrix setting
    always_comb
    begin
        nxt_pix_d1  = pix_in;
        nxt_pix_out = table_bypass ? pix_d1_ff : csc_pixel_s'(rd_data);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pix_d1_ff  <= '0;
            pix_out_ff <= '0;
        end
        else
        begin
            pix_d1_ff  <= nxt_pix_d1;
            pix_out_ff <= nxt_pix_out;
        end
    end

    assign pix_out = pix_out_ff;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_sub_write;
        evt_seen && evt_ff.kind == EV_SUB && evt_ff.data >= `CSC_SUB_RED
            && evt_ff.data <= `CSC_SUB_ALL |=> table_rw_direction;
    endproperty
    a_sub_write: assert property (p_sub_write) else $error("table not in write mode");

    property p_stop_read;
        evt_seen && evt_ff.kind == EV_STOP |=> !table_rw_direction [*2];
    endproperty
    a_stop_read: assert property (p_stop_read) else $error("table not back to read");

    property p_first_addr;
        evt_seen && evt_ff.kind == EV_DATA && first_ff && |we_mask(tsel_ff)
            |=> addr_ff == $past(evt_ff.data) && we_ff == '0;
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("start address not loaded");

    property p_step;
        |we_ff |-> addr_ff == 8'(waddr_ff + `CSC_ADDR_STEP);
    endproperty
    a_step: assert property (p_step) else $error("address counter did not step");

    property p_strobe;
        |we_ff |-> $past(evt_seen) && $past(evt_ff.kind) == EV_DATA
            && wdata_ff == $past(evt_ff.data);
    endproperty
    a_strobe: assert property (p_strobe) else $error("write without a data byte");

    property p_all;
        |we_ff && $past(tsel_ff) == TS_ALL |-> &we_ff;
    endproperty
    a_all: assert property (p_all) else $error("broadcast missed a table");

    property p_ctrl;
        evt_seen && evt_ff.kind == EV_DATA && tsel_ff == TS_CTRL
            |=> ctrl_ff == $past(evt_ff.data) ##1 $stable(ctrl_ff) || evt_seen;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control byte not taken");

    property p_ignore;
        evt_seen && evt_ff.kind == EV_DATA && tsel_ff == TS_NONE
            |=> $stable(ctrl_ff) && we_ff == '0;
    endproperty
    a_ignore: assert property (p_ignore) else $error("unmapped write had effect");

    property p_bypass;
        table_bypass |=> pix_out == $past(pix_d1_ff);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong");

    property p_lookup;
        !table_bypass |=> pix_out == $past(rd_data);
    endproperty
    a_lookup: assert property (p_lookup) else $error("lookup path wrong");

endmodule : csc_i2c_control_lut_loader

// ==== sim/csc_bus_master.sv ====
// behavioural serial bus master that writes bytes to the converter receiver
// assumes a pull-up on the data line; the device's pull enters as dev_pull
`timescale 1ns/100ps
module csc_bus_master #(
    parameter int HALF = 600
) (
    input  wire logic dev_pull,
    output logic      scl,
    output logic      sda
);
    logic drive_low;

    // ---------------------------------------------------------------
    // open drain wire
    // ---------------------------------------------------------------
    // a released line floats up to the pull-up level
    assign sda = (drive_low || dev_pull) ? 1'b0 : 1'b1;

    // bus idles with both lines released
    initial
    begin
        scl = 1'b1;
        drive_low = 1'b0;
    end

    // start: data falls while the clock is high
    task automatic start();
        drive_low = 1'b1;
        #HALF scl = 1'b0;
    endtask : start

    // msb first, then a released acknowledge slot sampled at the clock rise
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--)
        begin
            #(HALF/4) drive_low = (i >= 0) ? !b[i] : 1'b0;
            #(HALF - HALF/4) scl = 1'b1;
            if (i < 0)
                ack = !sda;
            #HALF scl = 1'b0;
        end
    endtask : put

    // stop: data rises while the clock is high
    task automatic stop();
        #(HALF/4) drive_low = 1'b1;
        #(HALF - HALF/4) scl = 1'b1;
        #HALF drive_low = 1'b0;
        #HALF;
    endtask : stop
endmodule : csc_bus_master

// ==== sim/testbench.sv ====
// self-checking bench: control writes, table loads and the pixel lookup path
// assumes the bus master model file and the design package are compiled first
`timescale 1ns/100ps
`include "csc_i2c_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD at %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
    import csc_pkg::*;
    localparam logic [6:0] BUS_ADDR = 7'h3A;  // value arbitrary
    logic       clock, resetn, i2c_clk, scl, sda, sda_oe, table_bypass;
    logic       table_rw_direction, matrix_enable, input_pass_enable, output_drive_enable;
    logic [2:0] input_format_sel;
    csc_filter_e filter_mode;
    csc_pixel_s  pix_in, pix_out;
    logic [7:0]  d [$];
    int          fail_count, comparisons, cycles;

    csc_bus_master m (.dev_pull(sda_oe), .scl(scl), .sda(sda));

    csc_i2c_control_lut_loader #(.DEV_ADDR(BUS_ADDR)) uut (
        .clock(clock), .resetn(resetn), .i2c_clk(i2c_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe(sda_oe), .pix_in(pix_in), .table_bypass(table_bypass),
        .pix_out(pix_out), .input_format_sel(input_format_sel), .filter_mode(filter_mode),
        .matrix_enable(matrix_enable), .input_pass_enable(input_pass_enable),
        .output_drive_enable(output_drive_enable), .table_rw_direction(table_rw_direction));

    // ---------------------------------------------------------------
    // clocks and hang guard
    // ---------------------------------------------------------------
    // pixel clock at 100 MHz
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // link clock, offset so its edges never line up with the pixel clock
    initial
    begin
        i2c_clk = 1'b0;
        #37;
        forever #62.5 i2c_clk = ~i2c_clk;
    end

    // about 40k cycles are needed; the ceiling leaves ample margin
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            fail_count++;
            summarize();
        end
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // control outputs against a control byte; filter choice worked out here
    task automatic ctl_chk(input logic [7:0] v);
        csc_filter_e f;
        f = (v[2:0] <= 3'h1) ? FLT_411 : ((v[2:0] <= 3'h3) ? FLT_422 : FLT_BYPASS);
        `CHK(input_format_sel, v[2:0])
        `CHK(filter_mode, f)
        `CHK(matrix_enable, v[3])
        `CHK(input_pass_enable, v[4])
        `CHK(output_drive_enable, v[5])
    endtask : ctl_chk

    // one write transfer: address, sub-address, data bytes, stop
    task automatic wr(input logic [7:0] sub, input logic [7:0] q [$]);
        logic ack;
        m.start();
        m.put({BUS_ADDR, `CSC_RW_WRITE}, ack);
        `CHK(ack, 1'b1)
        m.put(sub, ack);
        `CHK(ack, 1'b1)
        foreach (q[i])
        begin
            m.put(q[i], ack);
            `CHK(ack, 1'b1)
            `CHK(table_rw_direction, (sub != 8'h00 && sub <= 8'h04))
            if (sub == 8'h00)
                ctl_chk(q[i]);
        end
        m.stop();
        repeat (100) @(negedge clock);
        `CHK(table_rw_direction, 1'b0)
    endtask : wr

    // address settles under bypass, one clock of lookup, then bypass checked one clock after
    // unloaded table words read as unknown, so lookup only at loaded addresses
    task automatic look(input csc_pixel_s p, input csc_pixel_s e);
        pix_in = p;
        repeat (2) @(negedge clock);
        table_bypass = 1'b0;
        @(negedge clock);
        `CHK(pix_out, e)
        table_bypass = 1'b1;
        @(negedge clock);
        `CHK(pix_out, p)
    endtask : look

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial
    begin
        pix_in = '0;
        // tables hold no known data yet, so the lookup path stays bypassed
        table_bypass = 1'b1;
        resetn = 1'b0;
        @(negedge clock);
        // held long enough to cover three link clock periods too
        repeat (40) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        ctl_chk(8'h24);
        `CHK(table_rw_direction, 1'b0)
        $display("test reset done");
        repeat (100) @(negedge clock);
        d = '{8'h38, 8'h01, 8'h0A, 8'h13, 8'h24, 8'h3F};
        wr(8'h00, d);
        $display("test control done");
        d = '{8'hFE, 8'h11, 8'h22, 8'h33};
        wr(8'h01, d);
        d = '{8'h10, 8'h44};
        wr(8'h02, d);
        d = '{8'h10, 8'h55};
        wr(8'h03, d);
        d = '{8'h20, 8'h66, 8'h77};
        wr(8'h04, d);
        d = '{8'h21, 8'h88};
        wr(8'h01, d);
        d = '{8'h20, 8'h99, 8'h99};
        wr(8'h05, d);
        ctl_chk(8'h3F);
        $display("test loads done");
        @(negedge clock);
        look({8'hFE, 8'h10, 8'h10}, {8'h11, 8'h44, 8'h55});
        look({8'hFF, 8'h20, 8'h20}, {8'h22, 8'h66, 8'h66});
        look({8'h00, 8'h21, 8'h21}, {8'h33, 8'h77, 8'h77});
        look({8'h21, 8'h21, 8'h20}, {8'h88, 8'h77, 8'h66});
        $display("test lookup done");
        // restart in mid-run: control must fall back to its reset values
        resetn = 1'b0;
        repeat (40) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        ctl_chk(8'h24);
        `CHK(table_rw_direction, 1'b0)
        $display("test restart done");
        summarize();
    end
endmodule : testbench
